// File: design/bpf_defines.vh
// Behaviour
// - a pattern fill tiles the 8x8 pattern over the whole destination rectangle.
// - pattern is 64 bytes, 64-aligned at 8 bpp, or 128 bytes, 128-aligned at 16 bpp.
// - each pattern pixel meets the destination pixel through one of sixteen raster codes.
// - after start the engine writes the whole destination area unaided.
// - source address picks the pattern start phase; the tile wraps from that phase.
// - operation field bits 3-0: 6h fill with raster code, 7h transparent fill, 0Bh expand.
// - operation register bits 19-16 hold the raster code.
// - width and height registers hold size minus one; engine does one more of each.
// - row pitch register in 16-bit words advances rectangular rows.
// - writing 1 to control bit 0 starts the programmed operation.
// - destination and source linear bits pick rectangle (0) or linear (1) addressing.
// - start addresses are byte addresses; destination at 8010h, source at 800Ch.
// - transparent fill leaves a pixel alone when the pattern equals the background colour.
// - expansion writes foreground for a 1 bit and background for a 0 bit.
// - expansion supports rectangle to rectangle and a linear source or destination.
`ifndef BPF_DEFINES_VH
`define BPF_DEFINES_VH

`define BPF_A_CTRL      16'h8000
`define BPF_A_STATUS    16'h8004
`define BPF_A_OPER      16'h8008
`define BPF_A_SRC       16'h800C
`define BPF_A_DST       16'h8010
`define BPF_A_PITCH     16'h8014
`define BPF_A_WIDTH     16'h8018
`define BPF_A_HEIGHT    16'h801C
`define BPF_A_BG        16'h8020
`define BPF_A_FG        16'h8024

`define BPF_CTRL_START  0
`define BPF_CTRL_DLIN   16
`define BPF_CTRL_SLIN   17
`define BPF_CTRL_DEPTH  18
`define BPF_STAT_BUSY   0
`define BPF_OP_LSB      0
`define BPF_OP_MSB      3
`define BPF_ROP_LSB     16
`define BPF_ROP_MSB     19

`define BPF_OP_FILL_ROP 4'h6
`define BPF_OP_FILL_TR  4'h7
`define BPF_OP_EXPAND   4'hB

`define BPF_PAT_SIDE    3'h7
`define BPF_MASK_8BPP   32'hFFFF_FFC0
`define BPF_MASK_16BPP  32'hFFFF_FF80

`define BPF_RST_32      32'h0000_0000
`define BPF_RST_16      16'h0000
`define BPF_RST_4       4'h0

`endif

// File: design/bpf_engine.v
`timescale 1ns/1ps
`include "bpf_defines.vh"

module bpf_engine (
	// clock and reset
	input  wire        i_clk_sys,
	input  wire        i_reset,
	// register port
	input  wire [15:0] i_addr,
	input  wire [31:0] i_wdata,
	input  wire        i_wr,
	input  wire        i_rd,
	output reg  [31:0] o_rdata,
	// display memory port
	output reg  [31:0] o_mem_addr,
	output reg         o_mem_rd,
	output reg         o_mem_wr,
	output reg         o_mem_wide,
	output reg  [15:0] o_mem_wdata,
	input  wire [15:0] i_mem_rdata,
	// status
	output wire        o_busy
);

	localparam [2:0] S_IDLE = 3'd0;
	localparam [2:0] S_SRC  = 3'd1;
	localparam [2:0] S_SW   = 3'd2;
	localparam [2:0] S_SLAT = 3'd3;
	localparam [2:0] S_DRD  = 3'd4;
	localparam [2:0] S_DW   = 3'd5;
	localparam [2:0] S_DLAT = 3'd6;
	localparam [2:0] S_WR   = 3'd7;

	// software-visible setup
	reg        depth16;
	reg        dst_lin;
	reg        src_lin;
	reg [3:0]  op_sel;
	reg [3:0]  rop;
	reg [31:0] src_addr;
	reg [31:0] dst_addr;
	reg [15:0] pitch;
	reg [15:0] width_m1;
	reg [15:0] height_m1;
	reg [15:0] bg_col;
	reg [15:0] fg_col;

	// walking state
	reg [2:0]  state;
	reg        busy;
	reg [15:0] x_cnt;
	reg [15:0] y_cnt;
	reg [31:0] dst_row;
	reg [31:0] dst_cur;
	reg [31:0] src_row;
	reg [31:0] src_cur;
	reg [31:0] pat_base;
	reg [2:0]  phase_x;
	reg [2:0]  pat_x;
	reg [2:0]  pat_y;
	reg [2:0]  bit_idx;
	reg [7:0]  mono;
	reg [15:0] src_pix;
	reg [15:0] dst_pix;

	wire        is_rop   = (op_sel == `BPF_OP_FILL_ROP);
	wire        is_tr    = (op_sel == `BPF_OP_FILL_TR);
	wire        is_exp   = (op_sel == `BPF_OP_EXPAND);
	wire        op_ok    = is_rop | is_tr | is_exp;
	wire        start    = i_wr & (i_addr == `BPF_A_CTRL) & i_wdata[`BPF_CTRL_START];
	wire        last_x   = (x_cnt == width_m1);
	wire        last_y   = (y_cnt == height_m1);
	wire [31:0] bpp      = depth16 ? 32'h0000_0002 : 32'h0000_0001;
	wire        start_d16 = i_wdata[`BPF_CTRL_DEPTH];
	wire [31:0] pat_addr = pat_base + (depth16 ? {25'h000_0000, pat_y, pat_x, 1'b0}
	                                           : {26'h000_0000, pat_y, pat_x});
	wire [15:0] pix_mask = depth16 ? 16'hFFFF : 16'h00FF;
	wire        mono_bit = mono[3'd7 - bit_idx];
	wire        transp   = ((src_pix & pix_mask) == (bg_col & pix_mask));

	assign o_busy = busy;

	// per-bit raster combination indexed by {pattern, destination}
	function [15:0] rop_mix;
		input [3:0]  code;
		input [15:0] p;
		input [15:0] d;
		integer k;
		begin
			rop_mix = 16'h0000;
			for (k = 0; k < 16; k = k + 1) begin
				rop_mix[k] = code[{p[k], d[k]}];
			end
		end
	endfunction

	// next row start of a rectangular area; the pitch counts 16-bit words
	function [31:0] row_step;
		input [31:0] base;
		input [15:0] words;
		begin
			row_step = base + {15'h0000, words, 1'b0};
		end
	endfunction

	// source byte pointer after one expanded bit; a byte is spent after its eighth bit
	function [31:0] src_step;
		input [31:0] addr;
		input [2:0]  idx;
		begin
			src_step = (idx == 3'h7) ? addr + 32'h0000_0001 : addr;
		end
	endfunction

	// colour of the pixel about to be written
	reg [15:0] out_pix;
	always @* begin
		out_pix = src_pix;
		if (is_exp) begin
			out_pix = mono_bit ? fg_col : bg_col;
		end else if (is_rop) begin
			out_pix = rop_mix(rop, src_pix, dst_pix);
		end
		out_pix = out_pix & pix_mask;
	end

	// register writes; setup is frozen while busy so a stray write cannot bend a running walk
	always @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			depth16   <= 1'b0;
			dst_lin   <= 1'b0;
			src_lin   <= 1'b0;
			op_sel    <= `BPF_RST_4;
			rop       <= `BPF_RST_4;
			src_addr  <= `BPF_RST_32;
			dst_addr  <= `BPF_RST_32;
			pitch     <= `BPF_RST_16;
			width_m1  <= `BPF_RST_16;
			height_m1 <= `BPF_RST_16;
			bg_col    <= `BPF_RST_16;
			fg_col    <= `BPF_RST_16;
		end else if (i_wr && !busy) begin
			case (i_addr)
				`BPF_A_CTRL: begin
					depth16 <= i_wdata[`BPF_CTRL_DEPTH];
					dst_lin <= i_wdata[`BPF_CTRL_DLIN];
					src_lin <= i_wdata[`BPF_CTRL_SLIN];
				end
				`BPF_A_OPER: begin
					op_sel <= i_wdata[`BPF_OP_MSB:`BPF_OP_LSB];
					rop    <= i_wdata[`BPF_ROP_MSB:`BPF_ROP_LSB];
				end
				`BPF_A_SRC:    src_addr  <= i_wdata;
				`BPF_A_DST:    dst_addr  <= i_wdata;
				`BPF_A_PITCH:  pitch     <= i_wdata[15:0];
				`BPF_A_WIDTH:  width_m1  <= i_wdata[15:0];
				`BPF_A_HEIGHT: height_m1 <= i_wdata[15:0];
				`BPF_A_BG:     bg_col    <= i_wdata[15:0];
				`BPF_A_FG:     fg_col    <= i_wdata[15:0];
				default: begin
				end
			endcase
		end
	end

	// register reads, data in the cycle after the strobe; unmapped reads return zero
	always @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			o_rdata <= `BPF_RST_32;
		end else if (i_rd) begin
			case (i_addr)
				`BPF_A_CTRL:   o_rdata <= {13'h0000, depth16, src_lin, dst_lin, 15'h0000, busy};
				`BPF_A_STATUS: o_rdata <= {31'h0000_0000, busy};
				`BPF_A_OPER:   o_rdata <= {12'h000, rop, 12'h000, op_sel};
				`BPF_A_SRC:    o_rdata <= src_addr;
				`BPF_A_DST:    o_rdata <= dst_addr;
				`BPF_A_PITCH:  o_rdata <= {16'h0000, pitch};
				`BPF_A_WIDTH:  o_rdata <= {16'h0000, width_m1};
				`BPF_A_HEIGHT: o_rdata <= {16'h0000, height_m1};
				`BPF_A_BG:     o_rdata <= {16'h0000, bg_col};
				`BPF_A_FG:     o_rdata <= {16'h0000, fg_col};
				default:       o_rdata <= `BPF_RST_32;
			endcase
		end else begin
			o_rdata <= `BPF_RST_32;
		end
	end

	// the walk: fetch source, optionally fetch destination, write, advance
	always @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			state       <= S_IDLE;
			busy        <= 1'b0;
			x_cnt       <= `BPF_RST_16;
			y_cnt       <= `BPF_RST_16;
			dst_row     <= `BPF_RST_32;
			dst_cur     <= `BPF_RST_32;
			src_row     <= `BPF_RST_32;
			src_cur     <= `BPF_RST_32;
			pat_base    <= `BPF_RST_32;
			phase_x     <= 3'h0;
			pat_x       <= 3'h0;
			pat_y       <= 3'h0;
			bit_idx     <= 3'h0;
			mono        <= 8'h00;
			src_pix     <= `BPF_RST_16;
			dst_pix     <= `BPF_RST_16;
			o_mem_addr  <= `BPF_RST_32;
			o_mem_rd    <= 1'b0;
			o_mem_wr    <= 1'b0;
			o_mem_wide  <= 1'b0;
			o_mem_wdata <= `BPF_RST_16;
		end else begin
			o_mem_rd <= 1'b0;
			o_mem_wr <= 1'b0;
			case (state)
				S_IDLE: begin
					// busy holds through the cycle that presents the last write
					busy <= 1'b0;
					// a start with an operation this block does not run is ignored
					if (start && op_ok && !busy) begin
						busy       <= 1'b1;
						state      <= S_SRC;
						// depth arrives in the start write itself, so take it from the bus
						o_mem_wide <= start_d16;
						x_cnt      <= `BPF_RST_16;
						y_cnt      <= `BPF_RST_16;
						dst_row    <= dst_addr;
						dst_cur    <= dst_addr;
						src_row    <= src_addr;
						src_cur    <= src_addr;
						bit_idx    <= 3'h0;
						if (start_d16) begin
							pat_base <= src_addr & `BPF_MASK_16BPP;
							phase_x  <= src_addr[3:1];
							pat_x    <= src_addr[3:1];
							pat_y    <= src_addr[6:4];
						end else begin
							pat_base <= src_addr & `BPF_MASK_8BPP;
							phase_x  <= src_addr[2:0];
							pat_x    <= src_addr[2:0];
							pat_y    <= src_addr[5:3];
						end
					end
				end
				S_SRC: begin
					if (is_exp && (bit_idx != 3'h0)) begin
						state <= S_WR;
					end else begin
						o_mem_rd   <= 1'b1;
						o_mem_addr <= is_exp ? src_cur : pat_addr;
						state      <= S_SW;
					end
				end
				S_SW: begin
					state <= S_SLAT;
				end
				S_SLAT: begin
					mono    <= i_mem_rdata[7:0];
					src_pix <= i_mem_rdata & pix_mask;
					state   <= is_rop ? S_DRD : S_WR;
				end
				S_DRD: begin
					o_mem_rd   <= 1'b1;
					o_mem_addr <= dst_cur;
					state      <= S_DW;
				end
				S_DW: begin
					state <= S_DLAT;
				end
				S_DLAT: begin
					dst_pix <= i_mem_rdata & pix_mask;
					state   <= S_WR;
				end
				S_WR: begin
					if (!(is_tr && transp)) begin
						o_mem_wr    <= 1'b1;
						o_mem_addr  <= dst_cur;
						o_mem_wdata <= out_pix;
					end
					if (!last_x) begin
						x_cnt   <= x_cnt + 16'h0001;
						dst_cur <= dst_cur + bpp;
						pat_x   <= pat_x + 3'h1;
						bit_idx <= bit_idx + 3'h1;
						src_cur <= src_step(src_cur, bit_idx);
						state <= S_SRC;
					end else begin
						x_cnt <= `BPF_RST_16;
						y_cnt <= y_cnt + 16'h0001;
						pat_x <= phase_x;
						pat_y <= pat_y + 3'h1;
						if (dst_lin) begin
							dst_cur <= dst_cur + bpp;
						end else begin
							dst_row <= row_step(dst_row, pitch);
							dst_cur <= row_step(dst_row, pitch);
						end
						if (src_lin) begin
							bit_idx <= bit_idx + 3'h1;
							src_cur <= src_step(src_cur, bit_idx);
						end else begin
							bit_idx <= 3'h0;
							src_row <= row_step(src_row, pitch);
							src_cur <= row_step(src_row, pitch);
						end
						if (last_y) begin
							// busy drops one cycle later, in idle, as this write lands
							state <= S_IDLE;
						end else begin
							state <= S_SRC;
						end
					end
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

endmodule

// File: test/bpf_engine_props.sv
`timescale 1ns/1ps
module bpf_engine_props (
	// clock and reset
	input wire        i_clk_sys,
	input wire        i_reset,
	// register port
	input wire [15:0] i_addr,
	input wire [31:0] i_wdata,
	input wire        i_wr,
	input wire        i_rd,
	input wire [31:0] o_rdata,
	// memory port and status
	input wire [31:0] o_mem_addr,
	input wire        o_mem_rd,
	input wire        o_mem_wr,
	input wire        o_mem_wide,
	input wire [15:0] o_mem_wdata,
	input wire [15:0] i_mem_rdata,
	input wire        o_busy
);
	reg  [3:0]  op;
	reg  [15:0] bg;
	reg  [15:0] fg;
	reg         dep;
	wire        wok  = i_wr && !o_busy;
	wire        go   = wok && i_addr == 16'h8000 && i_wdata[0];
	wire        good = op == 4'h6 || op == 4'h7 || op == 4'hB;
	wire [15:0] m    = dep ? 16'hFFFF : 16'h00FF;
	// shadow of setup state; writes while busy are dropped, as in the engine
	always @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			op <= 4'h0;
			bg <= 16'h0000;
			fg <= 16'h0000;
			dep <= 1'b0;
		end else if (wok) begin
			if (i_addr == 16'h8008) op <= i_wdata[3:0];
			if (i_addr == 16'h8020) bg <= i_wdata[15:0];
			if (i_addr == 16'h8024) fg <= i_wdata[15:0];
			if (i_addr == 16'h8000) dep <= i_wdata[18];
		end
	end
	default clocking dc @(posedge i_clk_sys);
	endclocking
	default disable iff (i_reset);
	AST_START_BUSY: assert property (go && good |=> o_busy)
		else $error("start did not raise busy");
	AST_BAD_OP: assert property (go && !good |=> !o_busy)
		else $error("unsupported operation started");
	AST_IDLE_QUIET: assert property (!o_busy |-> !o_mem_rd && !o_mem_wr)
		else $error("memory access while idle");
	AST_END_ON_WRITE: assert property ($fell(o_busy) && op != 4'h7 |-> $past(o_mem_wr))
		else $error("busy fell without a final write");
	AST_RDATA_ONE: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000)
		else $error("read data outside its cycle");
	AST_WIDE_DEPTH: assert property (o_mem_wr |-> o_mem_wide == dep)
		else $error("write width differs from depth");
	AST_HIGH_ZERO: assert property (o_mem_wr && !dep |-> o_mem_wdata[15:8] == 8'h00)
		else $error("upper lane set at 8 bpp");
	AST_TRANSP: assert property (o_mem_wr && op == 4'h7 |-> (o_mem_wdata & m) != (bg & m))
		else $error("transparent colour written");
	AST_EXPAND: assert property (o_mem_wr && op == 4'hB |-> o_mem_wdata == (fg & m) || o_mem_wdata == (bg & m))
		else $error("expansion wrote a foreign colour");
	cover property (go && good);
	cover property ($fell(o_busy));
	cover property (o_mem_wr && op == 4'h7);
endmodule

// File: test/bpf_engine_tb_top.sv
`timescale 1ns/1ps
module bpf_engine_tb_top;
	reg         i_clk_sys, i_reset, i_wr, i_rd;
	reg  [15:0] i_addr;
	reg  [31:0] i_wdata;
	wire [31:0] o_rdata, o_mem_addr;
	wire        o_mem_rd, o_mem_wr, o_mem_wide, o_busy;
	wire [15:0] o_mem_wdata, i_mem_rdata;
	reg  [31:0] seed = 32'h7410, rv, sp, dp;
	reg  [7:0]  exp_mem [0:4095];
	integer     err_total = 0, samples_checked = 0, cyc = 0, i, k, r, c, n, a, s;
	reg  [3:0]  op, code;
	reg  [15:0] w, h, bg, fg, p, d, v;
	reg         dep, dlin, slin;
	bpf_engine bpf_engine_inst (.i_clk_sys, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.o_mem_addr, .o_mem_rd, .o_mem_wr, .o_mem_wide, .o_mem_wdata, .i_mem_rdata, .o_busy);
	bpf_mem_model bpf_mem_model_inst (.i_clk_sys(i_clk_sys), .i_addr(o_mem_addr), .i_rd(o_mem_rd),
		.i_wr(o_mem_wr), .i_wide(o_mem_wide), .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
	function [31:0] xs(input [31:0] x);
		begin
			x = x ^ (x << 13);
			x = x ^ (x >> 17);
			xs = x ^ (x << 5);
		end
	endfunction
	task chk(input [31:0] got, input [31:0] want);
		begin
			samples_checked = samples_checked + 1;
			if (got !== want) begin
				err_total = err_total + 1;
				$display("mismatch t=%0t got=%h exp=%h", $time, got, want);
			end
		end
	endtask
	task wr(input [15:0] ad, input [31:0] dv);
		begin
			@(posedge i_clk_sys);
			i_wr <= 1'b1;
			i_addr <= ad;
			i_wdata <= dv;
			@(posedge i_clk_sys);
			i_wr <= 1'b0;
		end
	endtask
	task rd(input [15:0] ad);
		begin
			@(posedge i_clk_sys);
			i_rd <= 1'b1;
			i_addr <= ad;
			@(posedge i_clk_sys);
			i_rd <= 1'b0;
			@(negedge i_clk_sys);
			rv = o_rdata;
		end
	endtask
	task set(input [15:0] ad, input [31:0] dv, input [31:0] mk);
		begin
			wr(ad, dv);
			rd(ad);
			chk(rv, dv & mk);
		end
	endtask
	// reference fill of the shadow memory, pixel by pixel in engine order
	task calc;
		for (r = 0; r <= h; r = r + 1)
			for (c = 0; c <= w; c = c + 1) begin
				n = r * (w + 1) + c;
				a = dlin ? dp + n * (dep + 1) : dp + r * 64 + c * (dep + 1);
				if (op == 4'hB) begin
					s = slin ? sp * 8 + n : (sp + r * 64) * 8 + c;
					v = exp_mem[s / 8][7 - s % 8] ? fg : bg;
				end else begin
					s = (((sp >> (3 + dep)) + r) % 8 * 8 + ((sp >> dep) + c) % 8) * (dep + 1);
					p = dep ? {exp_mem[s + 1], exp_mem[s]} : {8'h00, exp_mem[s]};
					d = dep ? {exp_mem[a + 1], exp_mem[a]} : {8'h00, exp_mem[a]};
					for (k = 0; k < 16; k = k + 1)
						v[k] = code[{p[k], d[k]}];
					if (op == 4'h7) v = p;
				end
				if (op != 4'h7 || ((p ^ bg) & (dep ? 16'hFFFF : 16'h00FF))) begin
					exp_mem[a] = v[7:0];
					if (dep) exp_mem[a + 1] = v[15:8];
				end
			end
	endtask
	task results;
		begin
			$display("checks %0d mismatches %0d", samples_checked, err_total);
			if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
			else $display("[ FAIL ]");
			$finish;
		end
	endtask
	initial begin
		i_clk_sys = 1'b0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end
	always @(posedge i_clk_sys) begin
		cyc = cyc + 1;
		if (cyc == 60000) begin
			err_total = err_total + 1;
			results;
		end
	end
	initial begin
		{i_reset, i_wr, i_rd, i_addr, i_wdata} = {1'b1, 50'h0};
		// pattern holds only 0 and 1 bytes so the transparent colour really occurs
		for (k = 0; k < 4096; k = k + 1) begin
			seed = xs(seed);
			exp_mem[k] = k < 128 ? {7'h00, seed[0]} : seed[7:0];
			bpf_mem_model_inst.mem[k] = exp_mem[k];
		end
		repeat (2) @(posedge i_clk_sys);
		i_reset <= 1'b0;
		for (i = 0; i < 26; i = i + 1) begin
			seed = xs(seed);
			op = i < 16 ? 4'h6 : (i < 21 ? 4'h7 : 4'hB);
			code = i[3:0];
			{dep, slin, dlin} = seed[2:0];
			w = {12'h000, seed[7:4] | 4'h1};
			h = {13'h0000, seed[10:8]};
			bg = op == 4'h7 ? {7'h00, seed[11], 7'h00, seed[12]} : seed[31:16];
			fg = seed[27:12];
			sp = op == 4'hB ? 32'h0000_0100 + seed[20:16] : seed[22:16] & (dep ? 32'h0000_007F : 32'h0000_003F);
			dp = 32'h0000_0400 + seed[29:24];
			set(16'h8008, {seed[31:20], code, seed[11:0] & 12'h000, op}, 32'h000F_000F);
			set(16'h800C, sp, 32'hFFFF_FFFF);
			set(16'h8010, dp, 32'hFFFF_FFFF);
			set(16'h8014, {seed[31:16], 16'h0020}, 32'h0000_FFFF);
			set(16'h8018, {seed[15:0], w}, 32'h0000_FFFF);
			set(16'h801C, h, 32'h0000_FFFF);
			set(16'h8020, bg, 32'h0000_FFFF);
			set(16'h8024, fg, 32'h0000_FFFF);
			wr(16'h8000, {13'h0000, dep, slin, dlin, 15'h0000, 1'b1});
			rd(16'h8004);
			chk(rv[0], 1'b1);
			wr(16'h8018, 32'h0000_00FF);
			while (rv[0] === 1'b1) rd(16'h8004);
			chk(rv, 32'h0000_0000);
			rd(16'h8018);
			chk(rv, w);
			calc;
			for (k = 0; k < 4096; k = k + 1)
				chk(bpf_mem_model_inst.mem[k], exp_mem[k]);
		end
		wr(16'h8008, 32'h0000_0005);
		wr(16'h8000, 32'h0000_0001);
		rd(16'h8004);
		chk(rv, 32'h0000_0000);
		rd(16'h8028);
		chk(rv, 32'h0000_0000);
		results;
	end
endmodule
bind bpf_engine bpf_engine_props bpf_engine_props_inst (.i_clk_sys, .i_reset, .i_addr, .i_wdata, .i_wr,
	.i_rd, .o_rdata, .o_mem_addr, .o_mem_rd, .o_mem_wr, .o_mem_wide, .o_mem_wdata, .i_mem_rdata, .o_busy);

// File: test/bpf_mem_model.sv
`timescale 1ns/1ps
module bpf_mem_model (
	// clock
	input  wire        i_clk_sys,
	// access from the engine
	input  wire [31:0] i_addr,
	input  wire        i_rd,
	input  wire        i_wr,
	input  wire        i_wide,
	input  wire [15:0] i_wdata,
	// read data, valid only in the cycle after i_rd
	output reg  [15:0] o_rdata = 16'h5A5A
);
	reg [7:0]  mem [0:4095];
	reg [11:0] a;
	always @(posedge i_clk_sys) begin
		a = i_addr[11:0];
		// wide pixels sit in consecutive bytes, low byte first
		if (i_rd)
			o_rdata <= i_wide ? {mem[a + 12'h001], mem[a]} : {8'h00, mem[a]};
		else
			o_rdata <= ~o_rdata; // stale data must never look like a valid answer
		if (i_wr) begin
			mem[a] <= i_wdata[7:0];
			if (i_wide)
				mem[a + 12'h001] <= i_wdata[15:8];
		end
	end
endmodule
